// [hdl/lpmc_defines.svh]
// Widths and timing counts of the low-power mode controller
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define LPMC_EVENT_LINES 16
`define LPMC_WAKE_PINS 6
`define LPMC_RTC_EVENTS 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LPMC_CLK_PERIOD_NS 5
`define LPMC_OSC_START_NS 4000
// Least time, so round up
`define LPMC_OSC_WAIT_CYC ((`LPMC_OSC_START_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS)
`define LPMC_OSC_CNT_W 16

`endif

// [hdl/lpmc_pkg.sv]
// Types shared by the low-power mode controller
package lpmc_pkg;

    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_SLEEP,
        LPMC_STOP,
        LPMC_STANDBY,
        LPMC_WAKE
    } lpmc_mode_t;

    typedef struct packed {
        lpmc_mode_t mode;
        logic core_clk_en;
        logic domain_clk_en;
        logic pll_en;
        logic fast_osc_en;
        logic xtal_osc_en;
        logic main_reg_en;
        logic lp_reg_en;
        logic under_drive;
        logic over_drive;
        logic retain;
        logic backup_retain;
        logic standby_flag;
        logic core_wake;
        logic core_rst_n;
        logic part_rst_n;
        logic debug_por_ok;
        logic gpio_ok;
        logic rtc_run;
        logic rtc_irq;
    } lpmc_state_t;

endpackage

// [hdl/lpmc_pin_edge.sv]
// Rising/falling edge catcher for the wakeup pins
`timescale 1ns/10ps
`include "lpmc_defines.svh"
module lpmc_pin_edge #(
    parameter int WIDTH = `LPMC_WAKE_PINS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Pins and edge selection
    input wire logic [WIDTH-1:0] pins_in,
    input wire logic [WIDTH-1:0] rise_en_in,
    input wire logic [WIDTH-1:0] fall_en_in,
    // Result
    output logic hit_out
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic armed;
        logic hit;
    } lpmc_edge_state_t;

    lpmc_edge_state_t st;
    lpmc_edge_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.prev = pins_in;
        // First sample after reset only loads history, so no false edge
        next_st.armed = 1'b1;
        next_st.hit = st.armed &&
            (|((pins_in & ~st.prev & rise_en_in) | (~pins_in & st.prev & fall_en_in)));
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hit_out = st.hit;
endmodule

// [hdl/lpmc_osc_wait.sv]
// Oscillator restart wait: ready must hold for a settle count
`timescale 1ns/10ps
`include "lpmc_defines.svh"
module lpmc_osc_wait #(
    parameter int CYCLES = `LPMC_OSC_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Control
    input wire logic start_in,
    input wire logic osc_ready_in,
    // Result
    output logic stable_out
);
    typedef struct packed {
        logic [`LPMC_OSC_CNT_W-1:0] count;
        logic stable;
    } lpmc_wait_state_t;

    localparam logic [`LPMC_OSC_CNT_W-1:0] LAST = CYCLES[`LPMC_OSC_CNT_W-1:0];

    lpmc_wait_state_t st;
    lpmc_wait_state_t next_st;

    always_comb begin
        next_st = st;
        // A dropped ready restarts the settle count
        if (!start_in || !osc_ready_in) begin
            next_st.count = '0;
            next_st.stable = 1'b0;
        end else if (st.count == LAST) begin
            next_st.stable = 1'b1;
        end else begin
            next_st.count = st.count + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stable_out = st.stable;
endmodule

// [hdl/lpmc_ctrl.sv]
// Low-power mode controller: Sleep, Stop and Standby sequencing
`timescale 1ns/10ps
`include "lpmc_defines.svh"
module lpmc_ctrl
    import lpmc_pkg::*;
#(
    parameter int EVENT_LINES = `LPMC_EVENT_LINES,
    parameter int WAKE_PINS = `LPMC_WAKE_PINS,
    parameter int OSC_WAIT_CYC = `LPMC_OSC_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Mode request from the core
    input wire logic enter_low_power_in,
    input wire logic deep_sleep_in,
    input wire logic standby_sel_in,
    // Configuration
    input wire logic reg_bypass_in,
    input wire logic lp_reg_sel_in,
    input wire logic under_drive_sel_in,
    input wire logic over_drive_req_in,
    input wire logic pll_req_in,
    input wire logic xtal_osc_req_in,
    input wire logic backup_sram_sel_in,
    input wire logic clear_standby_flag_in,
    input wire logic [WAKE_PINS-1:0] wake_rise_en_in,
    input wire logic [WAKE_PINS-1:0] wake_fall_en_in,
    input wire logic [`LPMC_RTC_EVENTS-1:0] rtc_irq_en_in,
    input wire logic rtc_slow_xtal_sel_in,
    input wire logic battery_mode_in,
    // Wakeup and exit sources
    input wire logic periph_irq_in,
    input wire logic [EVENT_LINES-1:0] external_event_lines_in,
    input wire logic supply_level_detector_in,
    input wire logic [`LPMC_RTC_EVENTS-1:0] rtc_event_in,
    input wire logic usb_wake_in,
    input wire logic eth_wake_in,
    input wire logic low_power_timer_one_in,
    input wire logic [WAKE_PINS-1:0] wakeup_pins_in,
    input wire logic external_reset_pin_n_in,
    input wire logic independent_watchdog_rst_in,
    input wire logic core_domain_reset_pin_n_in,
    // Oscillator status
    input wire logic osc_ready_in,
    // Clock and power controls
    output lpmc_mode_t mode_out,
    output logic core_clk_en_out,
    output logic domain_clk_en_out,
    output logic pll_en_out,
    output logic fast_osc_en_out,
    output logic xtal_osc_en_out,
    output logic main_reg_en_out,
    output logic lp_reg_en_out,
    output logic under_drive_out,
    output logic over_drive_out,
    // Retention and reset
    output logic retain_out,
    output logic backup_retain_out,
    output logic standby_flag_out,
    output logic core_wake_out,
    output logic core_rst_n_out,
    output logic part_rst_n_out,
    output logic debug_por_ok_out,
    output logic gpio_ok_out,
    // RTC
    output logic rtc_run_out,
    output logic rtc_irq_out
);
    // ----------------------------------------------------------------
    // Wake sources
    // ----------------------------------------------------------------
    lpmc_state_t st;
    lpmc_state_t next_st;
    logic pin_hit;
    logic osc_stable;
    logic rtc_any;
    logic stop_wake;
    logic sleep_wake;
    logic standby_exit;

    lpmc_pin_edge #(
        .WIDTH(WAKE_PINS)
    ) u_pin_edge (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .pins_in(wakeup_pins_in),
        .rise_en_in(wake_rise_en_in),
        .fall_en_in(wake_fall_en_in),
        .hit_out(pin_hit)
    );

    lpmc_osc_wait #(
        .CYCLES(OSC_WAIT_CYC)
    ) u_osc_wait (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .start_in(st.mode == LPMC_WAKE),
        .osc_ready_in(osc_ready_in),
        .stable_out(osc_stable)
    );

    assign rtc_any = |rtc_event_in;
    assign stop_wake = (|external_event_lines_in) || supply_level_detector_in || rtc_any ||
        usb_wake_in || eth_wake_in || low_power_timer_one_in;
    assign sleep_wake = periph_irq_in || stop_wake;
    assign standby_exit = !external_reset_pin_n_in || independent_watchdog_rst_in ||
        rtc_any || pin_hit;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.core_wake = 1'b0;
        next_st.rtc_irq = |(rtc_event_in & rtc_irq_en_in);
        // On battery only the slow crystal RTC runs; on external supply the RTC always runs
        next_st.rtc_run = rtc_slow_xtal_sel_in || !battery_mode_in;
        // Core supply sequencing is the outside's job; pin taken as given
        next_st.part_rst_n = !reg_bypass_in || core_domain_reset_pin_n_in;
        next_st.gpio_ok = !reg_bypass_in;
        next_st.debug_por_ok = !(reg_bypass_in && !core_domain_reset_pin_n_in);
        next_st.backup_retain = backup_sram_sel_in;
        if (clear_standby_flag_in) begin
            next_st.standby_flag = 1'b0;
        end
        unique case (st.mode)
            LPMC_RUN: begin
                next_st.core_clk_en = 1'b1;
                next_st.domain_clk_en = 1'b1;
                next_st.fast_osc_en = 1'b1;
                next_st.pll_en = pll_req_in;
                next_st.xtal_osc_en = xtal_osc_req_in;
                next_st.main_reg_en = !reg_bypass_in;
                next_st.lp_reg_en = 1'b0;
                next_st.under_drive = 1'b0;
                next_st.over_drive = over_drive_req_in && !reg_bypass_in;
                next_st.retain = 1'b1;
                next_st.core_rst_n = 1'b1;
                if (enter_low_power_in) begin
                    if (!deep_sleep_in) begin
                        next_st.mode = LPMC_SLEEP;
                        next_st.core_clk_en = 1'b0;
                    end else if (standby_sel_in && !reg_bypass_in) begin
                        next_st.mode = LPMC_STANDBY;
                        next_st.core_clk_en = 1'b0;
                        next_st.domain_clk_en = 1'b0;
                        next_st.pll_en = 1'b0;
                        next_st.fast_osc_en = 1'b0;
                        next_st.xtal_osc_en = 1'b0;
                        next_st.main_reg_en = 1'b0;
                        next_st.over_drive = 1'b0;
                        next_st.retain = 1'b0;
                        next_st.core_rst_n = 1'b0;
                    end else begin
                        // Bypassed standby request falls back to Stop
                        next_st.mode = LPMC_STOP;
                        next_st.core_clk_en = 1'b0;
                        next_st.domain_clk_en = 1'b0;
                        next_st.pll_en = 1'b0;
                        next_st.fast_osc_en = 1'b0;
                        next_st.xtal_osc_en = 1'b0;
                        next_st.over_drive = 1'b0;
                        next_st.main_reg_en = !lp_reg_sel_in && !reg_bypass_in;
                        next_st.lp_reg_en = lp_reg_sel_in && !reg_bypass_in;
                        next_st.under_drive = under_drive_sel_in && !reg_bypass_in;
                        next_st.retain = 1'b1;
                    end
                end
            end
            LPMC_SLEEP: begin
                next_st.over_drive = st.over_drive && !reg_bypass_in;
                if (sleep_wake) begin
                    next_st.mode = LPMC_RUN;
                    next_st.core_clk_en = 1'b1;
                    next_st.core_wake = 1'b1;
                end
            end
            LPMC_STOP: begin
                if (reg_bypass_in) begin
                    next_st.under_drive = 1'b0;
                end
                if (stop_wake) begin
                    next_st.mode = LPMC_WAKE;
                    next_st.fast_osc_en = 1'b1;
                    next_st.main_reg_en = !reg_bypass_in;
                    next_st.lp_reg_en = 1'b0;
                    next_st.under_drive = 1'b0;
                end
            end
            LPMC_STANDBY: begin
                if (standby_exit) begin
                    next_st.mode = LPMC_WAKE;
                    next_st.standby_flag = 1'b1;
                    next_st.fast_osc_en = 1'b1;
                    next_st.main_reg_en = !reg_bypass_in;
                end
            end
            LPMC_WAKE: begin
                // Clocks held off until the oscillator has settled
                if (osc_stable && osc_ready_in) begin
                    next_st.mode = LPMC_RUN;
                    next_st.core_clk_en = 1'b1;
                    next_st.domain_clk_en = 1'b1;
                    next_st.core_wake = 1'b1;
                    next_st.core_rst_n = 1'b1;
                    next_st.retain = 1'b1;
                end
            end
            default: begin
                next_st.mode = LPMC_RUN;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.mode <= LPMC_RUN;
            st.core_clk_en <= 1'b1;
            st.domain_clk_en <= 1'b1;
            st.fast_osc_en <= 1'b1;
            st.main_reg_en <= 1'b1;
            st.retain <= 1'b1;
            st.core_rst_n <= 1'b1;
            st.part_rst_n <= 1'b1;
            st.debug_por_ok <= 1'b1;
            st.gpio_ok <= 1'b1;
            st.rtc_run <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign mode_out = st.mode;
    assign core_clk_en_out = st.core_clk_en;
    assign domain_clk_en_out = st.domain_clk_en;
    assign pll_en_out = st.pll_en;
    assign fast_osc_en_out = st.fast_osc_en;
    assign xtal_osc_en_out = st.xtal_osc_en;
    assign main_reg_en_out = st.main_reg_en;
    assign lp_reg_en_out = st.lp_reg_en;
    assign under_drive_out = st.under_drive;
    assign over_drive_out = st.over_drive;
    assign retain_out = st.retain;
    assign backup_retain_out = st.backup_retain;
    assign standby_flag_out = st.standby_flag;
    assign core_wake_out = st.core_wake;
    assign core_rst_n_out = st.core_rst_n;
    assign part_rst_n_out = st.part_rst_n;
    assign debug_por_ok_out = st.debug_por_ok;
    assign gpio_ok_out = st.gpio_ok;
    assign rtc_run_out = st.rtc_run;
    assign rtc_irq_out = st.rtc_irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_sleep_core_gate: assert property (
        st.mode == LPMC_RUN && enter_low_power_in && !deep_sleep_in |=>
        mode_out == LPMC_SLEEP && !core_clk_en_out && domain_clk_en_out [*2])
        else $error("Sleep entry did not gate only the core clock");
    a_sleep_wake: assert property (
        mode_out == LPMC_SLEEP && periph_irq_in |=>
        mode_out == LPMC_RUN && core_clk_en_out && core_wake_out ##1 !core_wake_out)
        else $error("Sleep did not end on a peripheral interrupt");
    a_stop_clocks_off: assert property (
        mode_out == LPMC_STOP |->
        !domain_clk_en_out && !pll_en_out && !fast_osc_en_out && !xtal_osc_en_out)
        else $error("Clock or oscillator running in Stop");
    a_stop_retained: assert property (
        mode_out == LPMC_STOP |-> retain_out && core_rst_n_out)
        else $error("State not retained in Stop");
    a_stop_reg_sel: assert property (
        st.mode == LPMC_RUN && enter_low_power_in && deep_sleep_in && !standby_sel_in &&
        !reg_bypass_in |=> mode_out == LPMC_STOP && lp_reg_en_out == $past(lp_reg_sel_in) &&
        main_reg_en_out == !$past(lp_reg_sel_in) && under_drive_out == $past(under_drive_sel_in))
        else $error("Stop regulator setting wrong");
    a_stop_wake: assert property (
        mode_out == LPMC_STOP && (|external_event_lines_in) |=>
        mode_out == LPMC_WAKE && fast_osc_en_out)
        else $error("Event line did not wake Stop");
    a_standby_off: assert property (
        mode_out == LPMC_STANDBY |-> !main_reg_en_out && !lp_reg_en_out &&
        !pll_en_out && !fast_osc_en_out && !xtal_osc_en_out)
        else $error("Supply or oscillator on in Standby");
    a_standby_lost: assert property (
        mode_out == LPMC_STANDBY |-> !retain_out && !core_rst_n_out)
        else $error("Standby kept core state");
    a_standby_exit: assert property (
        mode_out == LPMC_STANDBY && independent_watchdog_rst_in |=>
        mode_out == LPMC_WAKE && standby_flag_out && !core_rst_n_out)
        else $error("Watchdog did not end Standby");
    a_no_standby: assert property (
        reg_bypass_in && st.mode == LPMC_RUN && enter_low_power_in && deep_sleep_in |=>
        mode_out == LPMC_STOP)
        else $error("Standby entered with regulator bypassed");
    a_no_drive: assert property (
        reg_bypass_in |=> !over_drive_out && !under_drive_out)
        else $error("Drive mode active with regulator bypassed");
    a_part_reset: assert property (
        reg_bypass_in && !core_domain_reset_pin_n_in |=>
        !part_rst_n_out && !gpio_ok_out && !debug_por_ok_out)
        else $error("Core reset pin not honoured when bypassed");
    a_rtc_irq: assert property (
        |(rtc_event_in & rtc_irq_en_in) |=> rtc_irq_out)
        else $error("RTC event raised no interrupt");
    a_rtc_battery: assert property (
        battery_mode_in && !rtc_slow_xtal_sel_in |=> !rtc_run_out)
        else $error("RTC on internal slow clock ran on battery");
    a_osc_wait: assert property (
        mode_out == LPMC_WAKE && !osc_ready_in |=> !domain_clk_en_out && !core_clk_en_out)
        else $error("Clocks released before oscillator ready");

    c_sleep_trip: cover property (
        mode_out == LPMC_SLEEP ##1 mode_out == LPMC_RUN);
    c_stop_trip: cover property (
        mode_out == LPMC_WAKE ##1 mode_out == LPMC_RUN && !retain_out == 1'b0);
    c_standby_trip: cover property (
        mode_out == LPMC_STANDBY ##1 mode_out == LPMC_WAKE);
endmodule

// [dv/lpmc_supervisor.sv]
// Behavioural reset supervisor and fast oscillator facing the controller
`timescale 1ns/10ps
module lpmc_supervisor #(
    parameter int PWRUP_CYC = 3,
    parameter int OSC_START_CYC = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Requests from the bench
    input wire logic ext_rst_req_in,
    input wire logic supply_sag_in,
    input wire logic osc_en_in,
    // Pins and status toward the controller
    output logic ext_reset_pin_n_out,
    output logic core_pin_n_out,
    output logic osc_ready_out
);
    int up;
    int osc;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            up <= 0;
            osc <= 0;
            core_pin_n_out <= 1'h0;
            ext_reset_pin_n_out <= 1'h1;
            osc_ready_out <= 1'h0;
        end else begin
            if (up < PWRUP_CYC) begin
                up <= up + 1;
            end
            // Held low through supply ramp and on any sag
            core_pin_n_out <= (up >= PWRUP_CYC - 1) && !supply_sag_in;
            // Driven apart from the core pin
            ext_reset_pin_n_out <= !ext_rst_req_in;
            // Ready only after a start-up delay; drops at once when disabled
            osc <= osc_en_in ? ((osc < OSC_START_CYC) ? osc + 1 : osc) : 0;
            osc_ready_out <= osc_en_in && (osc == OSC_START_CYC);
        end
    end
endmodule

// [dv/tb_lpmc_ctrl.sv]
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`include "lpmc_defines.svh"
module tb_lpmc_ctrl;
    import lpmc_pkg::*;
    logic clk_in = 1'h0, arst_n = 1'h0, enter = 1'h0, deep = 1'h0, stby = 1'h0, bypass = 1'h0;
    logic lp_sel = 1'h0, ud_sel = 1'h0, od_req = 1'h0, pll_req = 1'h1, xtal_req = 1'h1;
    logic bk_sel = 1'h0, clr = 1'h0, slow_sel = 1'h0, batt = 1'h0, irq = 1'h0, lvl = 1'h0;
    logic usb = 1'h0, eth = 1'h0, lpt = 1'h0, wdg = 1'h0, ext_req = 1'h0, sag = 1'h0;
    logic [5:0] pins = 6'h01, rise_en = 6'h20, fall_en = 6'h01;
    logic [3:0] rtc_en = 4'ha, rtc_ev = 4'h0;
    logic [15:0] ev = 16'h0000;
    logic osc_rdy, ext_n, core_n, core_clk, dom_clk, pll_en, fosc, xosc, mreg, lpreg;
    logic udrv, odrv, retain, bret, sflag, cwake, crst_n, prst_n, dbg_ok, gpio_ok, rtc_run, rtc_irq;
    lpmc_mode_t mode;
    int bad_count = 0, cmp_count = 0, cyc = 0;

    always #2.5 clk_in = ~clk_in;

    lpmc_ctrl #(.OSC_WAIT_CYC(4)) uut (.clk_in(clk_in), .arst_n_in(arst_n),
        .enter_low_power_in(enter), .deep_sleep_in(deep), .standby_sel_in(stby),
        .reg_bypass_in(bypass), .lp_reg_sel_in(lp_sel), .under_drive_sel_in(ud_sel),
        .over_drive_req_in(od_req), .pll_req_in(pll_req), .xtal_osc_req_in(xtal_req),
        .backup_sram_sel_in(bk_sel), .clear_standby_flag_in(clr), .wake_rise_en_in(rise_en),
        .wake_fall_en_in(fall_en), .rtc_irq_en_in(rtc_en), .rtc_slow_xtal_sel_in(slow_sel),
        .battery_mode_in(batt), .periph_irq_in(irq), .external_event_lines_in(ev),
        .supply_level_detector_in(lvl), .rtc_event_in(rtc_ev), .usb_wake_in(usb),
        .eth_wake_in(eth), .low_power_timer_one_in(lpt), .wakeup_pins_in(pins),
        .external_reset_pin_n_in(ext_n), .independent_watchdog_rst_in(wdg),
        .core_domain_reset_pin_n_in(core_n), .osc_ready_in(osc_rdy), .mode_out(mode),
        .core_clk_en_out(core_clk), .domain_clk_en_out(dom_clk), .pll_en_out(pll_en),
        .fast_osc_en_out(fosc), .xtal_osc_en_out(xosc), .main_reg_en_out(mreg),
        .lp_reg_en_out(lpreg), .under_drive_out(udrv), .over_drive_out(odrv),
        .retain_out(retain), .backup_retain_out(bret), .standby_flag_out(sflag),
        .core_wake_out(cwake), .core_rst_n_out(crst_n), .part_rst_n_out(prst_n),
        .debug_por_ok_out(dbg_ok), .gpio_ok_out(gpio_ok), .rtc_run_out(rtc_run),
        .rtc_irq_out(rtc_irq));

    lpmc_supervisor sup (.clk_in(clk_in), .arst_n_in(arst_n), .ext_rst_req_in(ext_req),
        .supply_sag_in(sag), .osc_en_in(fosc), .ext_reset_pin_n_out(ext_n),
        .core_pin_n_out(core_n), .osc_ready_out(osc_rdy));

    task chk_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask

    task chk_mode(input lpmc_mode_t e);
        cmp_count++;
        if (mode !== e) begin
            bad_count++;
            $display("BAD mode expected %0d seen %0d", e, mode);
        end
    endtask

    task wait_mode(input lpmc_mode_t m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk_mode(m);
    endtask

    task go_low(input logic d, input logic s);
        @(posedge clk_in);
        deep <= d;
        stby <= s;
        enter <= 1'h1;
        @(posedge clk_in);
        enter <= 1'h0;
        #1;
    endtask

    task stop_src(input int i, input logic v);
        case (i)
            0: ev[0] <= v;
            1: ev[15] <= v;
            2: lvl <= v;
            3: rtc_ev[1] <= v;
            4: usb <= v;
            5: eth <= v;
            default: lpt <= v;
        endcase
    endtask

    task sby_src(input int i, input logic v);
        case (i)
            0: ext_req <= v;
            1: wdg <= v;
            2: rtc_ev[3] <= v;
            3: pins[5] <= v;
            default: pins[0] <= !v;
        endcase
    endtask

    task t_sleep();
        go_low(1'h0, 1'h0);
        chk_mode(LPMC_SLEEP);
        chk_bit("core_clk", 1'h0, core_clk);
        chk_bit("dom_clk", 1'h1, dom_clk);
        chk_bit("pll_en", 1'h1, pll_en);
        @(posedge clk_in) irq <= 1'h1;
        @(posedge clk_in) irq <= 1'h0;
        #1 wait_mode(LPMC_RUN, 2);
        chk_bit("core_wake", 1'h1, cwake);
        go_low(1'h0, 1'h0);
        @(posedge clk_in) rtc_ev[1] <= 1'h1;
        @(posedge clk_in) rtc_ev[1] <= 1'h0;
        #1 wait_mode(LPMC_RUN, 2);
        $display("test sleep done");
    endtask

    task t_stop();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_in);
            lp_sel <= i[0];
            ud_sel <= i[1];
            go_low(1'h1, 1'h0);
            chk_mode(LPMC_STOP);
            chk_bit("dom_clk", 1'h0, dom_clk);
            chk_bit("pll_en", 1'h0, pll_en);
            chk_bit("osc", 1'h0, fosc | xosc);
            chk_bit("lp_reg", i[0], lpreg);
            chk_bit("main_reg", !i[0], mreg);
            chk_bit("udrv", i[1], udrv);
            chk_bit("retain", 1'h1, retain);
            @(posedge clk_in) irq <= 1'h1;
            @(posedge clk_in) irq <= 1'h0;
            #1 chk_mode(LPMC_STOP);
            @(posedge clk_in) stop_src(i, 1'h1);
            @(posedge clk_in) stop_src(i, 1'h0);
            #1 chk_mode(LPMC_WAKE);
            chk_bit("core_clk", 1'h0, core_clk);
            wait_mode(LPMC_RUN, 40);
            chk_bit("core_wake", 1'h1, cwake);
            chk_bit("retain", 1'h1, retain);
        end
        $display("test stop done");
    endtask

    task t_standby();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_in) bk_sel <= i[0];
            go_low(1'h1, 1'h1);
            chk_mode(LPMC_STANDBY);
            chk_bit("regs", 1'h0, mreg | lpreg);
            chk_bit("clocks", 1'h0, pll_en | fosc | xosc);
            chk_bit("retain", 1'h0, retain);
            chk_bit("core_rst_n", 1'h0, crst_n);
            chk_bit("bk_retain", i[0], bret);
            @(posedge clk_in);
            sby_src(i, 1'h1);
            clr <= (i == 1);
            @(posedge clk_in);
            sby_src(i, 1'h0);
            clr <= 1'h0;
            #1 wait_mode(LPMC_WAKE, 4);
            chk_bit("sflag", 1'h1, sflag);
            wait_mode(LPMC_RUN, 40);
            chk_bit("core_rst_n", 1'h1, crst_n);
            @(posedge clk_in) clr <= 1'h1;
            @(posedge clk_in) clr <= 1'h0;
            #1 chk_bit("sflag", 1'h0, sflag);
        end
        $display("test standby done");
    endtask

    task t_bypass();
        @(posedge clk_in) od_req <= 1'h1;
        repeat (2) @(posedge clk_in);
        #1 chk_bit("odrv", 1'h1, odrv);
        go_low(1'h0, 1'h0);
        @(posedge clk_in) bypass <= 1'h1;
        ud_sel <= 1'h1;
        repeat (2) @(posedge clk_in);
        #1 chk_bit("odrv", 1'h0, odrv);
        chk_bit("gpio_ok", 1'h0, gpio_ok);
        @(posedge clk_in) irq <= 1'h1;
        @(posedge clk_in) irq <= 1'h0;
        #1 wait_mode(LPMC_RUN, 2);
        go_low(1'h1, 1'h1);
        chk_mode(LPMC_STOP);
        chk_bit("udrv", 1'h0, udrv);
        chk_bit("regs", 1'h0, mreg | lpreg);
        @(posedge clk_in) sag <= 1'h1;
        repeat (3) @(posedge clk_in);
        #1 chk_bit("part_rst_n", 1'h0, prst_n);
        chk_bit("dbg_ok", 1'h0, dbg_ok);
        @(posedge clk_in) sag <= 1'h0;
        repeat (3) @(posedge clk_in);
        #1 chk_bit("part_rst_n", 1'h1, prst_n);
        @(posedge clk_in) usb <= 1'h1;
        @(posedge clk_in) usb <= 1'h0;
        #1 wait_mode(LPMC_RUN, 40);
        @(posedge clk_in) bypass <= 1'h0;
        od_req <= 1'h0;
        $display("test bypass done");
    endtask

    task t_rtc();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in) rtc_ev[i] <= 1'h1;
            @(posedge clk_in) rtc_ev[i] <= 1'h0;
            #1 chk_bit("rtc_irq", rtc_en[i], rtc_irq);
            @(posedge clk_in);
            slow_sel <= i[0];
            batt <= i[1];
            repeat (2) @(posedge clk_in);
            #1 chk_bit("rtc_run", i[0] | !i[1], rtc_run);
        end
        $display("test rtc done");
    endtask

    task give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk_in);
        arst_n <= 1'h1;
        repeat (5) @(posedge clk_in);
        t_sleep();
        t_stop();
        t_standby();
        t_bypass();
        t_rtc();
        give_verdict();
    end
endmodule
